// ### inc/smsi_defs.svh
// Constants for the switch monitor serial interface
`ifndef SMSI_DEFS_SVH
`define SMSI_DEFS_SVH
`define SMSI_WORD_BITS 24
`define SMSI_CNT_W 5
`define SMSI_RESET_BIT 22
`define SMSI_THERM_BIT 23
`define SMSI_DP_N 8
`define SMSI_GO_N 14
`define SMSI_OP_W 8
`define SMSI_CMD_SETTINGS 8'h01
`define SMSI_CMD_SLEEP 8'h05
`define SMSI_POL_RESET 8'hff
`define SMSI_WAKE_RESET 22'h3fffff
`define SMSI_FIFO_DEPTH 32
`endif

// ### inc/smsi_pkg.sv
// Types for the switch monitor serial interface
package smsi_pkg;
	typedef enum logic {SMSI_NORMAL, SMSI_SLEEP} smsi_mode_t;
endpackage : smsi_pkg

// ### verilog/smsi_serial_iface.sv
// Switch monitor serial slave with wake and interrupt control
//
// Overview of operation
// - Select fall enables output, captures status
// - Select rise first floats serial output
// - Select rise releases interrupt unless new change
// - Command takes effect at select rise
// - Select fall wakes from sleep with logic supply
// - Sample input bit on clock falling edge
// - Advance output bit on clock rising edge
// - Ignore clock and input while deselected
// - Commands are exactly 24 bits
// - Open reports zero, closed reports one
// - First rising edge shows top bit
// - Both words shift most significant first
// - Switch change in normal mode pulls interrupt low
// - Interrupt line fall wakes with wake high
// - Wake pin low in normal, released sleeping
// - Wake pin fall wakes, interrupt gating by supply
// - Select and interrupt wake need logic supply
// - Dual inputs closed by polarity setting
// - Ground inputs closed below reference
// - Battery supply acts as power-on reset
// - Reset flag bit 22 cleared at select rise
// - Every reply carries status and flags
// - Programming only in normal with supply
`timescale 1ns/100ps
`include "smsi_defs.svh"

module smsi_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Filling side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Draining side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	// Storage array
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0] count;
	logic doWrite;
	logic doRead;

	assign inReady = (count != (AW+1)'(DEPTH));
	assign outValid = (count != '0);
	assign doWrite = inValid && inReady;
	assign doRead = outValid && outReady;
	assign outData = mem[rdPtr];

	// Storage write
	always_ff @(posedge ref_clk)
	begin
		if (doWrite)
			mem[wrPtr] <= inData;
	end

	// Pointers and fill level
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end
		else
		begin
			if (doWrite)
				wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
			if (doRead)
				rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
			if (doWrite && !doRead)
				count <= count + 1'b1;
			else if (doRead && !doWrite)
				count <= count - 1'b1;
		end
	end
endmodule : smsi_fifo

module smsi_serial_iface #(
	parameter int WORD_BITS = `SMSI_WORD_BITS,
	parameter int FIFO_DEPTH = `SMSI_FIFO_DEPTH
) (
	// Clock and battery power-on reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Serial link pins
	input wire logic selectN,
	input wire logic serialClk,
	input wire logic serialIn,
	output logic serialOut,
	output logic serialOutEn,
	// Interrupt open-drain pin
	input wire logic intNIn,
	output logic intNOut,
	output logic intNOe,
	// Wake open-drain pin
	input wire logic wakeNIn,
	output logic wakeNOut,
	output logic wakeNOe,
	// Supply and comparators
	input wire logic logicSupplyOk,
	input wire logic [`SMSI_DP_N-1:0] dual_polarity_inputs,
	input wire logic [`SMSI_GO_N-1:0] ground_only_inputs,
	input wire logic thermalFlag,
	// Mode control and status
	input wire logic sleepRequest,
	output smsi_pkg::smsi_mode_t mode,
	// Accepted command stream
	output logic cmdValid,
	input wire logic cmdReady,
	output logic [WORD_BITS-1:0] cmdData
);
	import smsi_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic [1:0] selSync;
	logic [1:0] clkSync;
	logic [1:0] dinSync;
	logic [1:0] intSync;
	logic [1:0] wakeSync;
	logic [1:0] supSync;
	logic [1:0] thermSync; // Thermal flag from the sensor domain
	logic [`SMSI_DP_N-1:0] dpMeta;
	logic [`SMSI_DP_N-1:0] dpSync;
	logic [`SMSI_GO_N-1:0] goMeta;
	logic [`SMSI_GO_N-1:0] goSync;
	logic selPrev;
	logic clkPrev;
	logic intPrev;
	logic wakePrev;

	// Two-stage sync and previous level for edges
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			selSync <= 2'h3;
			clkSync <= 2'h0;
			dinSync <= 2'h0;
			intSync <= 2'h3;
			wakeSync <= 2'h3;
			supSync <= 2'h0;
			thermSync <= 2'h0;
			dpMeta <= '0;
			dpSync <= '0;
			goMeta <= '1;
			goSync <= '1;
			selPrev <= 1'b1;
			clkPrev <= 1'b0;
			intPrev <= 1'b1;
			wakePrev <= 1'b1;
		end
		else
		begin
			selSync <= {selSync[0], selectN};
			clkSync <= {clkSync[0], serialClk};
			dinSync <= {dinSync[0], serialIn};
			intSync <= {intSync[0], intNIn};
			wakeSync <= {wakeSync[0], wakeNIn};
			supSync <= {supSync[0], logicSupplyOk};
			thermSync <= {thermSync[0], thermalFlag};
			dpMeta <= dual_polarity_inputs;
			dpSync <= dpMeta;
			goMeta <= ground_only_inputs;
			goSync <= goMeta;
			selPrev <= selSync[1];
			clkPrev <= clkSync[1];
			intPrev <= intSync[1];
			wakePrev <= wakeSync[1];
		end
	end

	// Edge events
	logic selFall;
	logic selRise;
	logic sclkRise;
	logic sclkFall;
	logic intFall;
	logic wakeFall;
	logic supply;
	assign selFall = selPrev && !selSync[1];
	assign selRise = !selPrev && selSync[1];
	assign sclkRise = !selSync[1] && !clkPrev && clkSync[1];
	assign sclkFall = !selSync[1] && clkPrev && !clkSync[1];
	assign intFall = intPrev && !intSync[1];
	assign wakeFall = wakePrev && !wakeSync[1];
	assign supply = supSync[1];

	////////////////////////////////////////////////////////////////////////
	// Switch decode
	logic [`SMSI_DP_N-1:0] polarity; // One means switch to battery
	logic [`SMSI_GO_N+`SMSI_DP_N-1:0] switches;
	// Dual inputs: high closed for battery, low closed for ground
	assign switches = {~goSync, ~(dpSync ^ polarity)};

	////////////////////////////////////////////////////////////////////////
	// Shift registers
	logic [WORD_BITS-1:0] inShift;
	logic [WORD_BITS-1:0] outShift;
	logic [`SMSI_CNT_W-1:0] bitCount;
	logic resetFlag;
	logic [WORD_BITS-1:0] statusWord;
	logic intLatched;

	// Reply word: flags and switch status every time
	always_comb
	begin
		statusWord = '0;
		statusWord[`SMSI_GO_N+`SMSI_DP_N-1:0] = switches;
		statusWord[`SMSI_RESET_BIT] = resetFlag;
		statusWord[`SMSI_THERM_BIT] = thermSync[1];
	end

	// Serial input shift and bit count
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			inShift <= '0;
			bitCount <= '0;
		end
		else if (selFall)
		begin
			bitCount <= '0;
		end
		else if (sclkFall)
		begin
			inShift <= {inShift[WORD_BITS-2:0], dinSync[1]};
			if (bitCount != '1)
				bitCount <= bitCount + 1'b1;
		end
	end

	// Output shift: load at select fall, advance on rising edges
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			outShift <= '0;
			serialOut <= 1'b0;
			intLatched <= 1'b1;
		end
		else if (selFall)
		begin
			outShift <= statusWord;
			intLatched <= intSync[1];
			serialOut <= 1'b0;
		end
		else if (sclkRise)
		begin
			serialOut <= outShift[WORD_BITS-1];
			outShift <= {outShift[WORD_BITS-2:0], 1'b0};
		end
	end

	// Output driver enable follows select
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			serialOutEn <= 1'b0;
		else if (selFall)
			serialOutEn <= 1'b1;
		else if (selRise)
			serialOutEn <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Command acceptance
	logic fullWord;
	logic progOk;
	logic cmdPush;
	logic fifoInReady;
	assign fullWord = (bitCount == `SMSI_CNT_W'(WORD_BITS));
	assign progOk = (mode == SMSI_NORMAL) && supply;
	assign cmdPush = selRise && fullWord && progOk;

	// Polarity setting applied at select rise
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			polarity <= `SMSI_POL_RESET;
		else if (cmdPush && inShift[WORD_BITS-1:WORD_BITS-`SMSI_OP_W] == `SMSI_CMD_SETTINGS)
			polarity <= inShift[`SMSI_DP_N-1:0];
	end

	// Reset flag set by power-on, cleared at select rise
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			resetFlag <= 1'b1;
		else if (selRise)
			resetFlag <= 1'b0;
	end

	// Accepted commands, dropped when full
	smsi_fifo #(
		.WIDTH(WORD_BITS),
		.DEPTH(FIFO_DEPTH)
	) cmdFifo (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.inValid(cmdPush),
		.inReady(fifoInReady),
		.inData(inShift),
		.outValid(cmdValid),
		.outReady(cmdReady),
		.outData(cmdData)
	);

	////////////////////////////////////////////////////////////////////////
	// Mode control
	logic sleepCmd;
	logic wakeEvent;
	logic [`SMSI_GO_N+`SMSI_DP_N-1:0] prevSwitches;
	logic switchChange;
	assign sleepCmd = cmdPush && fifoInReady && (inShift[WORD_BITS-1:WORD_BITS-`SMSI_OP_W] == `SMSI_CMD_SLEEP);
	assign switchChange = (switches != prevSwitches);
	assign wakeEvent = (selFall && supply)
		|| (intFall && wakeSync[1] && supply)
		|| (wakeFall && (intSync[1] || !supply));

	// Mode machine
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			mode <= SMSI_NORMAL;
		else
		begin
			case (mode)
				SMSI_NORMAL:
				begin
					if (sleepRequest || sleepCmd)
						mode <= SMSI_SLEEP;
				end
				SMSI_SLEEP:
				begin
					if (wakeEvent)
						mode <= SMSI_NORMAL;
				end
				default:
					mode <= SMSI_NORMAL;
			endcase
		end
	end

	// Wake pin: driven low in normal, released in sleep
	assign wakeNOut = 1'b0;
	assign wakeNOe = (mode == SMSI_NORMAL);

	////////////////////////////////////////////////////////////////////////
	// Interrupt
	logic intPending;
	logic changeWhileSel;

	// Previous switch image
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			prevSwitches <= '0;
		else
			prevSwitches <= switches;
	end

	// Change during select holds the interrupt past the rise
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			changeWhileSel <= 1'b0;
		else if (selFall)
			changeWhileSel <= 1'b0;
		else if (!selSync[1] && switchChange && mode == SMSI_NORMAL)
			changeWhileSel <= 1'b1;
	end

	// Pending interrupt: set wins over clear
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			intPending <= 1'b0;
		else if (switchChange && mode == SMSI_NORMAL)
			intPending <= 1'b1;
		else if (selRise && !changeWhileSel)
			intPending <= 1'b0;
	end

	assign intNOut = 1'b0;
	assign intNOe = intPending;

	////////////////////////////////////////////////////////////////////////
	// Checks
	chk_oe_follows_sel: assert property (@(posedge ref_clk) disable iff (!resetn)
		selFall |=> serialOutEn)
		else $error("output not enabled after select fall");
	chk_oe_off_rise: assert property (@(posedge ref_clk) disable iff (!resetn)
		selRise |=> !serialOutEn)
		else $error("output still enabled after select rise");
	chk_int_release: assert property (@(posedge ref_clk) disable iff (!resetn)
		selRise && !changeWhileSel && !switchChange |=> !intNOe)
		else $error("interrupt not released");
	chk_int_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
		selRise && changeWhileSel |=> intNOe)
		else $error("interrupt wrongly released");
	chk_partial_drop: assert property (@(posedge ref_clk) disable iff (!resetn)
		selRise && !fullWord |=> $stable(polarity))
		else $error("partial command applied");
	chk_wake_pin: assert property (@(posedge ref_clk) disable iff (!resetn)
		wakeNOe == (mode == SMSI_NORMAL))
		else $error("wake pin mismatch");
	chk_sel_wake: assert property (@(posedge ref_clk) disable iff (!resetn)
		mode == SMSI_SLEEP && selFall && supply |=> mode == SMSI_NORMAL)
		else $error("select fall did not wake");
	chk_no_sup_wake: assert property (@(posedge ref_clk) disable iff (!resetn)
		mode == SMSI_SLEEP && !supply && !wakeFall |=> mode == SMSI_SLEEP)
		else $error("woke without logic supply");
	chk_reset_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
		selRise |=> !resetFlag)
		else $error("reset flag not cleared");
	chk_change_int: assert property (@(posedge ref_clk) disable iff (!resetn)
		switchChange && mode == SMSI_NORMAL |=> intNOe)
		else $error("change did not raise interrupt");
	chk_int_capture: assert property (@(posedge ref_clk) disable iff (!resetn)
		selFall |=> intLatched == $past(intSync[1]))
		else $error("interrupt level not captured at select fall");
	chk_wake_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
		mode == SMSI_SLEEP && wakeFall && supply && !intSync[1] && !selFall && !intFall |=> mode == SMSI_SLEEP)
		else $error("wake pin woke with interrupt low");

	cov_full_cmd: cover property (@(posedge ref_clk) disable iff (!resetn) cmdPush);
	cov_sleep_wake: cover property (@(posedge ref_clk) disable iff (!resetn)
		mode == SMSI_SLEEP ##1 mode == SMSI_NORMAL);
	cov_int_held: cover property (@(posedge ref_clk) disable iff (!resetn) selRise && changeWhileSel);
endmodule : smsi_serial_iface

// ### verif/smsi_mcu_model.sv
// Serial bus master model that drives the link pins
`timescale 1ns/100ps
module smsi_mcu_model (
	// Clock used only to align frames
	input wire logic ref_clk,
	// Link pins
	output logic selectN,
	output logic serialClk,
	output logic serialIn,
	input wire logic serialOut,
	input wire logic serialOutEn
);
	////////////////////////////////////////////////////////////
	// Idle levels, link clock parked low
	initial
	begin
		selectN = 1'b1;
		serialClk = 1'b0;
		serialIn = 1'b0;
	end
	// One frame of n pulses, MSB first, status sampled on falls
	task automatic xfer(input logic [23:0] cmd, input int n, output logic [23:0] st);
		st = 24'h0;
		@(posedge ref_clk);
		#1 selectN = 1'b0;
		#400;
		for (int i = 0; i < n; i++)
		begin
			serialIn = cmd[23 - i];
			serialClk = 1'b1;
			#400 serialClk = 1'b0;
			st = {st[22:0], serialOutEn ? serialOut : ~st[0]};
			#400;
		end
		selectN = 1'b1;
		serialIn = ~serialIn;
		#800;
	endtask : xfer
endmodule : smsi_mcu_model

// ### verif/smsi_serial_iface_bench.sv
// Self-checking bench for the switch monitor serial interface
`timescale 1ns/100ps
module smsi_serial_iface_bench;
	import smsi_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic selectN, serialClk, serialIn, serialOut, serialOutEn;
	logic intNOut, intNOe, wakeNOut, wakeNOe, cmdValid;
	logic intW, wakeW;
	logic intExtN = 1'b1;
	logic wakeExtN = 1'b1;
	logic supply = 1'b1;
	logic therm = 1'b1;
	logic sleepReq = 1'b0;
	logic cmdReady = 1'b0;
	logic [7:0] dualIn = 8'h5a;
	logic [13:0] gndIn = 14'h2c35;
	logic [7:0] pol = 8'hff;
	logic [23:0] cmdData;
	logic [2:0] mon;
	smsi_mode_t mode;
	int num_errors = 0;
	int n_checks = 0;
	////////////////////////////////////////////////////////////
	// Open-drain wires with pull-ups
	assign intW = (intNOe ? intNOut : 1'b1) & intExtN;
	assign wakeW = (wakeNOe ? wakeNOut : 1'b1) & wakeExtN;
	assign mon = {mode, intNOe, cmdValid};
	always #50 ref_clk = ~ref_clk;
	smsi_mcu_model mcu (.ref_clk(ref_clk), .selectN(selectN), .serialClk(serialClk),
		.serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn));
	smsi_serial_iface DUT (.ref_clk(ref_clk), .resetn(resetn), .selectN(selectN),
		.serialClk(serialClk), .serialIn(serialIn), .serialOut(serialOut),
		.serialOutEn(serialOutEn), .intNIn(intW), .intNOut(intNOut), .intNOe(intNOe),
		.wakeNIn(wakeW), .wakeNOut(wakeNOut), .wakeNOe(wakeNOe), .logicSupplyOk(supply),
		.dual_polarity_inputs(dualIn), .ground_only_inputs(gndIn), .thermalFlag(therm),
		.sleepRequest(sleepReq), .mode(mode), .cmdValid(cmdValid), .cmdReady(cmdReady),
		.cmdData(cmdData));
	////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up
	// Step to just after a rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		n_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Bounded wait on valid, interrupt or mode
	task automatic waitfor(input int w, input logic v);
		int k;
		k = 0;
		while (mon[w] !== v && k < 40)
		begin
			tick(1);
			k++;
		end
		chk("wait", {23'h0, v}, {23'h0, mon[w]});
		if (k == 40)
			wrap_up();
	endtask : waitfor
	// Pop one command and compare it
	task automatic pop(input logic [23:0] e);
		waitfor(0, 1'b1);
		chk("cmd", e, cmdData);
		cmdReady = 1'b1;
		tick(1);
		cmdReady = 1'b0;
		tick(1);
	endtask : pop
	// Status word from the live inputs
	function automatic logic [23:0] es(input logic rf);
		return {therm, rf, ~gndIn, ~(pol ^ dualIn)};
	endfunction : es
	////////////////////////////////////////////////////////////
	// First frame, reset flag, polarity setting
	task automatic t_first;
		logic [23:0] st;
		chk("oe idle", 24'h0, serialOutEn);
		mcu.xfer(24'h01000f, 24, st);
		chk("status", es(1'b1), st);
		chk("oe off", 24'h0, serialOutEn);
		pop(24'h01000f);
		pol = 8'h0f;
		mcu.xfer(24'h020000, 24, st);
		chk("status", es(1'b0), st);
		pop(24'h020000);
		$display("test first done");
	endtask : t_first
	// Short frame leaves settings alone
	task automatic t_partial;
		logic [23:0] st;
		mcu.xfer(24'h0100f0, 23, st);
		chk("no cmd", 24'h0, cmdValid);
		therm = 1'b0;
		mcu.xfer(24'h020000, 24, st);
		chk("status", es(1'b0), st);
		pop(24'h020000);
		$display("test partial done");
	endtask : t_partial
	// Switch change interrupt, held over a busy frame
	task automatic t_int;
		logic [23:0] st, old;
		dualIn[0] = ~dualIn[0];
		waitfor(1, 1'b1);
		old = es(1'b0);
		fork
			mcu.xfer(24'h020000, 24, st);
			begin
				tick(20);
				gndIn[0] = ~gndIn[0];
			end
		join
		chk("status", old, st);
		chk("int held", 24'h1, intNOe);
		pop(24'h020000);
		mcu.xfer(24'h020000, 24, st);
		chk("status", es(1'b0), st);
		chk("int free", 24'h0, intNOe);
		pop(24'h020000);
		$display("test interrupt done");
	endtask : t_int
	// Sleep entry and the wake sources
	task automatic t_sleep;
		logic [23:0] st;
		mcu.xfer(24'h050000, 24, st);
		pop(24'h050000);
		waitfor(2, 1'b1);
		chk("wake pin", 24'h0, wakeNOe);
		mcu.xfer(24'h0, 0, st);
		waitfor(2, 1'b0);
		chk("wake pin", 24'h1, wakeNOe);
		sleepReq = 1'b1;
		tick(1);
		sleepReq = 1'b0;
		waitfor(2, 1'b1);
		supply = 1'b0;
		mcu.xfer(24'h0100ff, 24, st);
		intExtN = 1'b0;
		tick(8);
		chk("mode", SMSI_SLEEP, mode);
		chk("no cmd", 24'h0, cmdValid);
		wakeExtN = 1'b0;
		waitfor(2, 1'b0);
		intExtN = 1'b1;
		wakeExtN = 1'b1;
		supply = 1'b1;
		sleepReq = 1'b1;
		tick(1);
		sleepReq = 1'b0;
		waitfor(2, 1'b1);
		intExtN = 1'b0;
		waitfor(2, 1'b0);
		intExtN = 1'b1;
		$display("test sleep done");
	endtask : t_sleep
	// Fill command queue past full, then drain
	task automatic t_fifo;
		logic [23:0] st;
		for (int i = 0; i < 33; i++)
			mcu.xfer(24'h020000 | 24'(i), 24, st);
		for (int i = 0; i < 32; i++)
			pop(24'h020000 | 24'(i));
		tick(10);
		chk("empty", 24'h0, cmdValid);
		$display("test queue done");
	endtask : t_fifo
	////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (5) @(posedge ref_clk);
		#1 resetn = 1'b1;
		tick(2);
		t_first();
		t_partial();
		t_int();
		t_sleep();
		t_fifo();
		wrap_up();
	end
endmodule : smsi_serial_iface_bench
